// ===== rtl/sacs_pkg.sv
package sacs_pkg;
  localparam int         CH_CNT         = 8;
  localparam int         CH_W           = 3;
  localparam int         RES_W          = 10;
  localparam int         IDX_W          = 6;
  localparam logic [5:0] IDX_MODE       = 6'h00;
  localparam logic [5:0] IDX_CHEN       = 6'h01;
  localparam logic [5:0] IDX_START      = 6'h02;
  localparam logic [5:0] IDX_STAT       = 6'h03;
  localparam logic [1:0] IDX_DATA_SEL   = 2'h1;
  localparam int         MODE_SCAN_LSB  = 0;
  localparam int         MODE_RES8_BIT  = 2;
  localparam int         MODE_INTEN_BIT = 3;
  localparam int         MODE_REF_BIT   = 4;
  localparam int         MODE_GO_BIT    = 5;
  localparam int         MODE_HALT_BIT  = 6;
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_DONE_BIT  = 1;
  localparam int         STAT_CH_LSB    = 2;
  localparam int         STAT_PASS_BIT  = 5;
  localparam int         SPI_WR_BIT     = 7;
  localparam logic [1:0] SCAN_STEP      = 2'h0;
  localparam logic [1:0] SCAN_ONCE      = 2'h1;
  localparam logic [1:0] SCAN_LOOP      = 2'h2;
  localparam logic [1:0] SCAN_RST       = 2'h0;
  localparam logic       RES8_RST       = 1'b0;
  localparam logic       INTEN_RST      = 1'b0;
  localparam logic       REF_RST        = 1'b0;
  localparam logic [7:0] CHEN_RST       = 8'h00;
  localparam logic [2:0] START_RST      = 3'h0;
  localparam int         OSC_MAX_HZ     = 1_000_000;
  localparam int         CONV10_TIME_US = 14;
  localparam int         CONV8_TIME_US  = 12;
  localparam logic [3:0] CONV10_OSC     =
    4'(CONV10_TIME_US * OSC_MAX_HZ / 1_000_000);
  localparam logic [3:0] CONV8_OSC      =
    4'(CONV8_TIME_US * OSC_MAX_HZ / 1_000_000);
endpackage

// ===== rtl/sacs_spi_slave.sv
`timescale 1ns/1ns
`default_nettype none

module sacs_spi_slave (
  // system
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // pins
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       ce_i,
  output logic            miso_o,
  output logic            miso_oe_n_o,
  // byte side
  input  wire logic [7:0] tx_byte_i,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_first_o
);

  typedef struct packed {
    logic       sck_s1;
    logic       sck_s2;
    logic       sck_q;
    logic       mosi_s1;
    logic       mosi_s2;
    logic       ce_s1;
    logic       ce_s2;
    logic       first;
    logic       rx_valid;
    logic       rx_first;
    logic [2:0] cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] rx_byte;
  } sacs_spi_state_type;

  sacs_spi_state_type s_ff;
  sacs_spi_state_type nxt_s;

  always_comb begin
    nxt_s          = s_ff;
    nxt_s.sck_s1   = sck_i;
    nxt_s.sck_s2   = s_ff.sck_s1;
    nxt_s.sck_q    = s_ff.sck_s2;
    nxt_s.mosi_s1  = mosi_i;
    nxt_s.mosi_s2  = s_ff.mosi_s1;
    nxt_s.ce_s1    = ce_i;
    nxt_s.ce_s2    = s_ff.ce_s1;
    nxt_s.rx_valid = 1'b0;
    if (!s_ff.ce_s2) begin
      // idle link: counters cleared, next byte is an address
      nxt_s.cnt   = 3'h0;
      nxt_s.first = 1'b1; // [RULE11]
      nxt_s.tx_sh = 8'h00;
    end else begin
      if (s_ff.sck_s2 && !s_ff.sck_q) begin
        if (s_ff.cnt == 3'h0) begin
          nxt_s.tx_sh = tx_byte_i; // [RULE12]
        end else begin
          nxt_s.tx_sh = {s_ff.tx_sh[6:0], 1'b0}; // [RULE12]
        end
      end
      if (!s_ff.sck_s2 && s_ff.sck_q) begin
        nxt_s.rx_sh = {s_ff.rx_sh[6:0], s_ff.mosi_s2}; // [RULE12]
        nxt_s.cnt   = s_ff.cnt + 3'h1;
        if (s_ff.cnt == 3'h7) begin
          nxt_s.rx_byte  = {s_ff.rx_sh[6:0], s_ff.mosi_s2};
          nxt_s.rx_valid = 1'b1;
          nxt_s.rx_first = s_ff.first; // [RULE11]
          nxt_s.first    = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign miso_o      = s_ff.tx_sh[7];
  assign miso_oe_n_o = ~s_ff.ce_s2; // [RULE11]
  assign rx_byte_o   = s_ff.rx_byte;
  assign rx_valid_o  = s_ff.rx_valid;
  assign rx_first_o  = s_ff.rx_first;

endmodule // sacs_spi_slave

`default_nettype wire

// ===== rtl/sacs_top.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// [RULE1] each of eight channels has an enable
// [RULE2] scan starts at start channel, skips disabled
// [RULE3] modes: step per command, one pass, continuous
// [RULE4] ten-bit result split over two bytes
// [RULE5] eight-bit result kept in one byte
// [RULE6] ten-bit conversion takes fourteen oscillator periods
// [RULE7] eight-bit conversion takes twelve oscillator periods
// [RULE8] status register is read-only
// [RULE9] software enables the interrupt output
// [RULE10] reference is supply or channel zero
// [RULE11] chip enable low resets serial logic
// [RULE12] shift out leading, latch trailing, msb first
// [RULE13] bytes after address are data transfers
// [RULE14] interrupt pin is open-drain, low active
// [RULE15] channel search wraps from seven to zero
module sacs_top #(
  parameter int CH_CNT = sacs_pkg::CH_CNT
) (
  // system
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // ahb-lite register slave
  input  wire logic                        hsel_i,
  input  wire logic [31:0]                 haddr_i,
  input  wire logic [1:0]                  htrans_i,
  input  wire logic                        hwrite_i,
  input  wire logic [2:0]                  hsize_i,
  input  wire logic [31:0]                 hwdata_i,
  input  wire logic                        hready_i,
  output logic [31:0]                      hrdata_o,
  output logic                             hreadyout_o,
  output logic                             hresp_o,
  // serial link pins
  input  wire logic                        sck_i,
  input  wire logic                        mosi_i,
  input  wire logic                        ce_i,
  output logic                             miso_o,
  output logic                             miso_oe_n_o,
  // interrupt pin, open-drain
  output logic                             int_n_o,
  output logic                             int_oe_n_o,
  // converter core
  input  wire logic                        osc_i,
  input  wire logic [sacs_pkg::RES_W-1:0]  conv_data_i,
  output logic [sacs_pkg::CH_W-1:0]        conv_chan_o,
  output logic                             conv_busy_o,
  output logic                             conv_8bit_o,
  output logic                             ref_sel_o
);

  import sacs_pkg::*;

  if (CH_CNT != 8) begin : g_bad_ch
    $error("sacs_top supports exactly eight channels");
  end

  // lengths are held in a four-bit counter; wider values would wrap
  if (CONV10_TIME_US * OSC_MAX_HZ / 1_000_000 > 15 ||
      CONV8_TIME_US * OSC_MAX_HZ / 1_000_000 > 15) begin : g_bad_osc
    $error("sacs_top conversion length exceeds counter");
  end

  // zero length would store on the aligning edge
  if (CONV10_OSC == 4'h0 || CONV8_OSC == 4'h0) begin : g_zero_osc
    $error("sacs_top needs nonzero conversion lengths");
  end

  // result byte split assumes a ten-bit converter
  if (RES_W != 10) begin : g_bad_res
    $error("sacs_top supports ten-bit results only");
  end

  typedef struct packed {
    logic            osc_s1;
    logic            osc_s2;
    logic            osc_q;
    logic [1:0]      scan;
    logic            res8;
    logic            int_en;
    logic            ref_sel;
    logic            go_req;
    logic            halt;
    logic [7:0]      chen;
    logic [2:0]      start_ch;
    logic [2:0]      cur_ch;
    logic [2:0]      first_ch;
    logic            busy;
    logic            done;
    logic            pass_end;
    logic [3:0]      osc_cnt;
    logic [7:0][7:0] res_hi;
    logic [7:0][7:0] res_lo;
    logic            spi_wr;
    logic [5:0]      spi_idx;
    logic            ahb_wr;
    logic [5:0]      ahb_idx;
    logic [7:0]      hrdata;
  } sacs_state_type;

  sacs_state_type s_ff;
  sacs_state_type nxt_s;
  logic [7:0]     tx_byte;
  logic [7:0]     rx_byte;
  logic           rx_valid;
  logic           rx_first;

  // first enabled channel at or after c, wrapping past seven
  function automatic logic [2:0] first_from(
    input logic [2:0] c,
    input logic [7:0] m
  );
    logic [2:0] k;
    logic [2:0] r;
    logic       hit;
    r   = c;
    hit = 1'b0;
    for (int i = 0; i < CH_CNT; i++) begin
      k = c + 3'(i); // [RULE15]
      if (!hit && m[k]) begin
        r   = k; // [RULE2]
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_reg(
    input sacs_state_type s,
    input logic [5:0]     idx
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_MODE: begin
        v[MODE_SCAN_LSB +: 2] = s.scan;
        v[MODE_RES8_BIT]      = s.res8;
        v[MODE_INTEN_BIT]     = s.int_en;
        v[MODE_REF_BIT]       = s.ref_sel;
        v[MODE_HALT_BIT]      = s.halt;
      end
      IDX_CHEN: begin
        v = s.chen;
      end
      IDX_START: begin
        v[2:0] = s.start_ch;
      end
      IDX_STAT: begin
        v[STAT_BUSY_BIT]     = s.busy;
        v[STAT_DONE_BIT]     = s.done;
        v[STAT_CH_LSB +: 3]  = s.cur_ch;
        v[STAT_PASS_BIT]     = s.pass_end;
      end
      default: begin
        if (idx[5:4] == IDX_DATA_SEL) begin
          if (idx[0]) begin
            v = s.res_lo[idx[3:1]];
          end else begin
            v = s.res_hi[idx[3:1]];
          end
        end
      end
    endcase
    return v;
  endfunction

  function automatic sacs_state_type wr_reg(
    input sacs_state_type s,
    input logic [5:0]     idx,
    input logic [7:0]     d
  );
    sacs_state_type r;
    r = s;
    case (idx)
      IDX_MODE: begin
        r.scan    = d[MODE_SCAN_LSB +: 2]; // [RULE3]
        r.res8    = d[MODE_RES8_BIT];
        r.int_en  = d[MODE_INTEN_BIT]; // [RULE9]
        r.ref_sel = d[MODE_REF_BIT]; // [RULE10]
        r.go_req  = d[MODE_GO_BIT];
        r.halt    = s.halt | d[MODE_HALT_BIT];
      end
      IDX_CHEN: begin
        r.chen = d; // [RULE1]
      end
      IDX_START: begin
        r.start_ch = d[2:0];
        // the scan pointer only moves while idle
        if (!s.busy) begin
          r.cur_ch = d[2:0]; // [RULE2]
        end
      end
      default: begin
        // status and result bytes ignore writes
        r = s; // [RULE8]
      end
    endcase
    return r;
  endfunction

  always_comb begin
    logic       ok;
    logic       more;
    logic [2:0] nxt_ch;
    logic [3:0] last;
    ok            = 1'b0;
    more          = 1'b0;
    nxt_ch        = 3'h0;
    last          = s_ff.res8 ? CONV8_OSC : CONV10_OSC; // [RULE6] [RULE7]
    nxt_s         = s_ff;
    nxt_s.osc_s1  = osc_i;
    nxt_s.osc_s2  = s_ff.osc_s1;
    nxt_s.osc_q   = s_ff.osc_s2;
    nxt_s.go_req  = 1'b0;
    tx_byte       = rd_reg(s_ff, s_ff.spi_idx);

    // bus data phase: write lands at the end of it
    if (s_ff.ahb_wr) begin
      nxt_s = wr_reg(nxt_s, s_ff.ahb_idx, hwdata_i[7:0]);
    end

    // bus address phase; read data captured here
    nxt_s.ahb_wr = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      ok = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0) &&
           (hsize_i == 3'h2);
      nxt_s.ahb_wr  = hwrite_i && ok;
      nxt_s.ahb_idx = haddr_i[7:2];
      nxt_s.hrdata  = ok ? rd_reg(s_ff, haddr_i[7:2]) : 8'h00;
      if (ok && !hwrite_i && haddr_i[7:2] == IDX_STAT) begin
        nxt_s.done     = 1'b0;
        nxt_s.pass_end = 1'b0;
      end
    end

    // serial link bytes
    if (rx_valid) begin
      if (rx_first) begin
        nxt_s.spi_idx = rx_byte[5:0]; // [RULE11]
        nxt_s.spi_wr  = rx_byte[SPI_WR_BIT];
      end else begin
        if (s_ff.spi_wr) begin
          nxt_s = wr_reg(nxt_s, s_ff.spi_idx, rx_byte); // [RULE13]
        end else if (s_ff.spi_idx == IDX_STAT) begin
          nxt_s.done     = 1'b0;
          nxt_s.pass_end = 1'b0;
        end
        nxt_s.spi_idx = s_ff.spi_idx + 6'h01; // [RULE13]
      end
    end

    // sequencer; placed last so a new event beats a clear
    if (!s_ff.busy) begin
      if (s_ff.go_req && (|s_ff.chen)) begin
        nxt_ch         = first_from(s_ff.cur_ch, s_ff.chen); // [RULE2]
        nxt_s.busy     = 1'b1;
        nxt_s.cur_ch   = nxt_ch;
        nxt_s.first_ch = nxt_ch;
        nxt_s.osc_cnt  = 4'h0;
        nxt_s.halt     = 1'b0;
        nxt_s.pass_end = 1'b0;
      end
    end else if (s_ff.osc_s2 && !s_ff.osc_q) begin
      // count 0 marks the aligning edge, so a full period follows
      if (s_ff.osc_cnt == last) begin
        if (s_ff.res8) begin
          nxt_s.res_hi[s_ff.cur_ch] = conv_data_i[RES_W-1 -: 8]; // [RULE5]
        end else begin
          nxt_s.res_hi[s_ff.cur_ch] = {6'h00, conv_data_i[9:8]}; // [RULE4]
          nxt_s.res_lo[s_ff.cur_ch] = conv_data_i[7:0]; // [RULE4]
        end
        nxt_ch        = first_from(s_ff.cur_ch + 3'h1, s_ff.chen); // [RULE15]
        nxt_s.cur_ch  = nxt_ch;
        nxt_s.done    = 1'b1;
        unique case (s_ff.scan)
          SCAN_LOOP: begin
            more = 1'b1; // [RULE3]
          end
          SCAN_ONCE: begin
            more = (nxt_ch != s_ff.first_ch); // [RULE3]
          end
          default: begin
            more = 1'b0; // [RULE3]
          end
        endcase
        more          = more && !s_ff.halt && (|s_ff.chen);
        nxt_s.busy    = more;
        nxt_s.osc_cnt = more ? 4'h1 : 4'h0;
        if (!more) begin
          nxt_s.halt     = 1'b0;
          nxt_s.pass_end = (s_ff.scan == SCAN_ONCE);
        end
      end else begin
        nxt_s.osc_cnt = s_ff.osc_cnt + 4'h1; // [RULE6] [RULE7]
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_ff          <= '0;
      s_ff.scan     <= SCAN_RST;
      s_ff.res8     <= RES8_RST;
      s_ff.int_en   <= INTEN_RST;
      s_ff.ref_sel  <= REF_RST;
      s_ff.chen     <= CHEN_RST;
      s_ff.start_ch <= START_RST;
      s_ff.cur_ch   <= START_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  sacs_spi_slave u_spi (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .sck_i       (sck_i),
    .mosi_i      (mosi_i),
    .ce_i        (ce_i),
    .miso_o      (miso_o),
    .miso_oe_n_o (miso_oe_n_o),
    .tx_byte_i   (tx_byte),
    .rx_byte_o   (rx_byte),
    .rx_valid_o  (rx_valid),
    .rx_first_o  (rx_first)
  );

  // zero-wait slave, never errors
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = {24'h000000, s_ff.hrdata};

  // pin only ever pulls low; pull-up gives the idle level
  assign int_n_o     = 1'b0; // [RULE14]
  assign int_oe_n_o  = ~(s_ff.int_en && s_ff.done); // [RULE9] [RULE14]

  assign conv_chan_o = s_ff.cur_ch;
  assign conv_busy_o = s_ff.busy;
  assign conv_8bit_o = s_ff.res8;
  assign ref_sel_o   = s_ff.ref_sel; // [RULE10]

endmodule // sacs_top

`default_nettype wire

// ===== sim/sacs_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module sacs_host_model (
  // serial pins
  output logic      sck_o,
  output logic      mosi_o,
  output logic      ce_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_n_i
);
  logic line;

  // released miso shows the inverse, so a stale bit never passes
  assign line = miso_oe_n_i ? ~miso_i : miso_i;

  initial begin
    sck_o  = 1'b0;
    mosi_o = 1'b1;
    ce_o   = 1'b0;
  end

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    if (!ce_o) begin
      #13 ce_o = 1'b1;
      #200;
    end
    // data moves well after the trailing edge, clear of the sync delay
    for (int i = 7; i >= 0; i--) begin
      #150 mosi_o = tx[i];
      #50 sck_o = 1'b1;
      #200 sck_o = 1'b0;
      rx[i] = line;
    end
    #200;
  endtask

  task automatic stop;
    #200 ce_o = 1'b0;
    mosi_o = ~mosi_o;
    #400;
  endtask
endmodule // sacs_host_model

`default_nettype wire

// ===== sim/sacs_top_checker.sv
`timescale 1ns/1ns
`default_nettype none

module sacs_top_checker
  import sacs_pkg::*;
#(
  parameter int CH_CNT = 8
) (
  // watched top ports
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire logic [31:0]     hrdata_o,
  input wire logic            hreadyout_o,
  input wire logic            hresp_o,
  input wire logic            ce_i,
  input wire logic            osc_i,
  input wire logic            miso_oe_n_o,
  input wire logic            int_n_o,
  input wire logic            int_oe_n_o,
  input wire logic [CH_W-1:0] conv_chan_o,
  input wire logic            conv_busy_o,
  input wire logic            conv_8bit_o
);
  logic            osc_q_ff;
  logic [CH_W-1:0] chan_q_ff;
  logic [4:0]      osc_n_ff;

  // raw oscillator rises since the pointer last moved; saturates
  always_ff @(posedge sys_clk_i) begin
    osc_q_ff  <= osc_i;
    chan_q_ff <= conv_chan_o;
    if (rst_i || !conv_busy_o || conv_chan_o != chan_q_ff)
      osc_n_ff <= 5'h00;
    else if (osc_i && !osc_q_ff && osc_n_ff != 5'h1f)
      osc_n_ff <= osc_n_ff + 5'h01;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_ready; hreadyout_o; endproperty
  a_ready: assert property (p_ready) else $error("hready low");
  property p_okay; !hresp_o; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_hi0; hrdata_o[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("read data upper bits set");
  property p_odval; int_n_o == 1'b0; endproperty
  a_odval: assert property (p_odval) else $error("int value high");
  property p_ceoff; (!ce_i) [*4] |-> miso_oe_n_o; endproperty
  a_ceoff: assert property (p_ceoff) else $error("miso driven");
  property p_cesel;
    !miso_oe_n_o |-> $past(ce_i, 2) || $past(ce_i, 3) || $past(ce_i, 4);
  endproperty
  a_cesel: assert property (p_cesel)
    else $error("miso without ce");
  property p_conv;
    $changed(conv_chan_o) && $past(conv_busy_o) |->
      osc_n_ff >= (conv_8bit_o ? 5'(CONV8_OSC) : 5'(CONV10_OSC));
  endproperty
  a_conv: assert property (p_conv)
    else $error("short conversion");
  property p_rst;
    $fell(rst_i) |-> !conv_busy_o && int_oe_n_o && miso_oe_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");

  c_busy: cover property ($rose(conv_busy_o));
  c_int: cover property ($fell(int_oe_n_o));
  c_spi: cover property ($fell(miso_oe_n_o));
endmodule // sacs_top_checker

bind sacs_top sacs_top_checker #(.CH_CNT(CH_CNT)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ce_i(ce_i),
  .osc_i(osc_i), .miso_oe_n_o(miso_oe_n_o), .int_n_o(int_n_o),
  .int_oe_n_o(int_oe_n_o), .conv_chan_o(conv_chan_o),
  .conv_busy_o(conv_busy_o), .conv_8bit_o(conv_8bit_o)
);

`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module tb_top;
  import sacs_pkg::*;
  logic        sys_clk_i, rst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, conv_chan_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic        sck_i, mosi_i, ce_i, miso_o, miso_oe_n_o, int_n_o, int_oe_n_o;
  logic        osc_i, conv_busy_o, conv_8bit_o, ref_sel_o;
  logic [9:0]  conv_data_i;
  int          err_total, comparisons, osc_cnt;

  function automatic logic [9:0] res(input logic [2:0] c);
    return {2'b10, 1'b0, c, 1'b1, c};
  endfunction

  task automatic report_and_stop;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic timeout(input int k, input int lim);
    if (k >= lim) begin
      err_total++;
      report_and_stop;
    end
  endtask

  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 20);
    timeout(k, 20);
  endtask

  // leading edge gives an idle cycle between transfers
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge sys_clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    rdy;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy;
    r = hrdata_o;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic chk_rd(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask

  task automatic chk_res(input logic [7:0] en);
    logic [9:0] v;
    for (int c = 0; c < CH_CNT; c++) begin
      v = en[c] ? res(3'(c)) : 10'h000;
      chk_rd(32'(32'h40 + 8 * c), {30'h0, v[9:8]});
      chk_rd(32'(32'h44 + 8 * c), {24'h0, v[7:0]});
    end
  endtask

  // go lands a few clocks after an osc rise, away from the sync window
  task automatic start(input logic [31:0] mode);
    @(posedge osc_i);
    repeat (5) @(posedge sys_clk_i);
    wr(32'h00, mode | 32'h20);
  endtask

  task automatic wait_chan(output int n);
    logic [2:0] c0;
    int         k, o0;
    c0 = conv_chan_o;
    o0 = osc_cnt;
    k = 0;
    while (conv_chan_o === c0 && k < 1000) begin
      @(posedge sys_clk_i);
      k++;
    end
    timeout(k, 1000);
    n = osc_cnt - o0;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (conv_busy_o !== 1'b0 && k < 2000) begin
      @(posedge sys_clk_i);
      k++;
    end
    timeout(k, 2000);
  endtask

  sacs_top i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .sck_i(sck_i), .mosi_i(mosi_i), .ce_i(ce_i), .miso_o(miso_o),
    .miso_oe_n_o(miso_oe_n_o), .int_n_o(int_n_o),
    .int_oe_n_o(int_oe_n_o), .osc_i(osc_i), .conv_data_i(conv_data_i),
    .conv_chan_o(conv_chan_o), .conv_busy_o(conv_busy_o),
    .conv_8bit_o(conv_8bit_o), .ref_sel_o(ref_sel_o)
  );

  sacs_host_model i_host (
    .sck_o(sck_i), .mosi_o(mosi_i), .ce_o(ce_i),
    .miso_i(miso_o), .miso_oe_n_i(miso_oe_n_o)
  );

  assign conv_data_i = res(conv_chan_o);

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    osc_i = 1'b0;
    #7;
    forever #500 osc_i = ~osc_i;
  end

  always @(posedge osc_i) osc_cnt++;

  initial begin
    logic [9:0] r7;
    logic [7:0] b;
    int         n;
    r7 = res(3'h7);
    rst_i    = 1'b1;
    hsel_i   = 1'b0;
    htrans_i = 2'h0;
    haddr_i  = 32'h0;
    hwrite_i = 1'b0;
    hsize_i  = 3'h2;
    hwdata_i = 32'h0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk_rd(32'h04, 32'h0);
    wr(32'h0c, 32'hff);
    chk_rd(32'h0c, 32'h0);
    wr(32'h3c, 32'hff);
    chk_rd(32'h3c, 32'h0);
    wr(32'h00, 32'h14);
    // write lands on the edge the task returns at; let it settle
    @(negedge sys_clk_i);
    `CHK(ref_sel_o, 1'b1)
    `CHK(conv_8bit_o, 1'b1)
    wr(32'h00, 32'h00);
    @(negedge sys_clk_i);
    `CHK(ref_sel_o, 1'b0)
    $display("test registers done");

    wr(32'h04, 32'ha2);
    wr(32'h08, 32'h05);
    start(32'h09);
    wait_chan(n);
    `CHK(n, CONV10_OSC + 1)
    `CHK(conv_chan_o, 3'h7)
    wait_chan(n);
    `CHK(conv_chan_o, 3'h1)
    wait_idle;
    `CHK(int_oe_n_o, 1'b0)
    chk_rd(32'h0c, 32'h36);
    `CHK(int_oe_n_o, 1'b1)
    chk_res(8'ha2);
    $display("test one pass done");

    wr(32'h04, 32'h81);
    wr(32'h08, 32'h07);
    start(32'h04);
    wait_chan(n);
    `CHK(n, CONV8_OSC + 1)
    `CHK(conv_chan_o, 3'h0)
    wait_idle;
    chk_rd(32'h78, {24'h0, r7[9:2]});
    chk_rd(32'h7c, {24'h0, r7[7:0]});
    chk_rd(32'h40, 32'h0);
    $display("test step done");

    wr(32'h04, 32'h09);
    wr(32'h08, 32'h00);
    start(32'h02);
    wait_chan(n);
    `CHK(conv_chan_o, 3'h3)
    wait_chan(n);
    `CHK(n, 32'(CONV10_OSC))
    `CHK(conv_chan_o, 3'h0)
    wait_chan(n);
    `CHK(conv_chan_o, 3'h3)
    wr(32'h00, 32'h42);
    wait_idle;
    chk_rd(32'h5c, {24'h0, 8'(res(3'h3))});
    $display("test loop done");

    `CHK(miso_oe_n_o, 1'b1)
    i_host.xfer(8'h81, b);
    i_host.xfer(8'h5a, b);
    i_host.stop;
    chk_rd(32'h04, 32'h5a);
    i_host.xfer(8'h1e, b);
    i_host.xfer(8'h00, b);
    `CHK(b, r7[9:2])
    i_host.xfer(8'h00, b);
    `CHK(b, r7[7:0])
    i_host.stop;
    i_host.xfer(8'h03, b);
    i_host.xfer(8'h00, b);
    `CHK(b, 8'h02)
    i_host.stop;
    chk_rd(32'h0c, 32'h0);
    $display("test serial done");
    report_and_stop;
  end
endmodule // tb_top

`default_nettype wire
